/* shared/shg_pkg.sv */
// Constants and types for the serial pause and low-supply guard block
package shg_pkg;
  // ****************************************
  // Instruction codes and frame layout
  // ****************************************
  localparam logic [7:0] CMD_WREN  = 8'h06;  // Set write enable
  localparam logic [7:0] CMD_WRITE_DISABLED_STATE  = 8'h04;  // Clear write enable
  localparam logic [7:0] CMD_STATUS_WRITE_COMMAND  = 8'h01;  // Status write command
  localparam logic [7:0] CMD_WRITE = 8'h02;  // Memory write
  localparam logic [5:0] CNT_ZERO  = 6'h00;  // Bit counter start
  localparam logic [5:0] CNT_OPC   = 6'h08;  // Opcode complete
  localparam logic [5:0] CNT_STATUS_WRITE_COMMAND  = 6'h10;  // Status frame length
  localparam logic [5:0] CNT_ADDR  = 6'h18;  // Opcode plus address
  localparam logic [2:0] BIT_LAST  = 3'h7;   // Last bit of a byte
  localparam int unsigned CLK_HZ   = 40_000_000;  // mclk rate
  localparam int unsigned PROG_US  = 4000;  // Programming time, us
  localparam int unsigned PROG_CYC = PROG_US * (CLK_HZ / 1_000_000);

  // Write engine states, Gray along idle-prog-done
  typedef enum logic [1:0] {
    WS_IDLE = 2'b00,
    WS_PROG = 2'b01,
    WS_DONE = 2'b11
  } shg_wstate_type;
endpackage : shg_pkg

/* rtl/shg_guard.sv */
// Serial slave front end with pause control and low-supply write guard
`timescale 1ns/1ps
`default_nettype none
module shg_guard #(
  parameter int unsigned PROG_CYCLES = shg_pkg::PROG_CYC  // Write time
) (
  input  wire logic        mclk,         // System clock
  input  wire logic        arst_n,       // Async reset, low
  input  wire logic        csPinN,       // Chip select pin, low active
  input  wire logic        sckPin,       // Serial clock pin
  input  wire logic        siPin,        // Serial data in pin
  input  wire logic        pausePinN,    // Pause pin, low active
  input  wire logic        lowSupply,    // Supply detector, high = low
  input  wire logic        areaProt,     // Addressed area is protected
  output logic             soOut,        // Serial data out value
  output logic             soOe,         // Serial data out enable
  output logic             paused,       // Pause state active
  output logic             writeEnableLatch, // Write enable latch
  output logic             writeBusy,    // Programming in progress
  output logic             statusWrite,  // Current job is status write
  output logic             cellUndefined,// Last programmed cell undefined
  output logic [7:0]       dataByte      // Last byte received
);
  import shg_pkg::*;

  // ****************************************
  // State record
  // ****************************************
  typedef struct packed {
    logic [1:0]     csS;      // Select synchroniser
    logic [1:0]     sckS;     // Clock synchroniser
    logic [1:0]     siS;      // Data synchroniser
    logic [1:0]     hldS;     // Pause synchroniser
    logic [1:0]     lowS;     // Supply synchroniser
    logic           sckD;     // Previous clock sample
    logic           pause;    // Pause state
    logic [5:0]     cnt;      // Bit counter
    logic [7:0]     shift;    // Input shifter
    logic [7:0]     opc;      // Captured opcode
    logic           write_enable_latch;      // Write enable latch
    logic           armed;    // Write frame acceptable
    logic           wrGo;     // Whole data byte received
    logic           soV;      // Output bit
    logic           soE;      // Output enable
    logic           undef;    // Interrupted cell flag
    logic           isSr;     // Job is status write
    shg_wstate_type ws;       // Write engine state
    logic [31:0]    tmr;      // Programming timer
  } shg_state_type;

  shg_state_type st_r;   // Registered state
  shg_state_type st_nxt; // Next state

  logic csN;      // Synchronised select
  logic sck;      // Synchronised clock
  logic sckRise;  // Clock rising edge
  logic sckFall;  // Clock falling edge
  logic low;      // Synchronised low supply
  logic hld;      // Synchronised pause input

  assign csN     = st_r.csS[1];
  assign sck     = st_r.sckS[1];
  assign low     = st_r.lowS[1];
  assign hld     = st_r.hldS[1];
  assign sckRise = sck & ~st_r.sckD;
  assign sckFall = ~sck & st_r.sckD;

  // ****************************************
  // Next state logic
  // ****************************************
  always_comb begin
    st_nxt      = st_r;
    // Two-stage synchronisers
    st_nxt.csS  = {st_r.csS[0], csPinN};
    st_nxt.sckS = {st_r.sckS[0], sckPin};
    st_nxt.siS  = {st_r.siS[0], siPin};
    st_nxt.hldS = {st_r.hldS[0], pausePinN};
    st_nxt.lowS = {st_r.lowS[0], lowSupply};
    st_nxt.sckD = sck;

    // Pause entry and exit on clock low or its falling edge
    if (csN) begin
      st_nxt.pause = 1'b0;
    end else if (!sck || sckFall) begin
      st_nxt.pause = ~hld;
    end

    if (csN) begin
      // Deselect: drop transfer, maybe launch write
      st_nxt.cnt   = CNT_ZERO;
      st_nxt.soE   = 1'b0;
      st_nxt.armed = 1'b0;
      st_nxt.wrGo  = 1'b0;
      if (st_r.wrGo && st_r.ws == WS_IDLE && !low) begin
        st_nxt.ws  = WS_PROG;
        st_nxt.tmr = 32'h0;
      end
    end else if (!st_r.pause) begin
      // Shift only while not paused
      if (sckRise) begin
        st_nxt.shift = {st_r.shift[6:0], st_r.siS[1]};
        if (st_r.cnt != 6'h3F) begin
          st_nxt.cnt = st_r.cnt + 6'h01;
        end
        if (st_nxt.cnt == CNT_OPC) begin
          st_nxt.opc = st_nxt.shift;
          // Accept only with latch set and engine idle
          st_nxt.armed = st_r.write_enable_latch && st_r.ws == WS_IDLE;
          if (st_nxt.shift == CMD_WREN && st_r.ws == WS_IDLE) begin
            st_nxt.write_enable_latch = 1'b1;
          end
          if (st_nxt.shift == CMD_WRITE_DISABLED_STATE) begin
            st_nxt.write_enable_latch = 1'b0;
          end
        end
        if (st_r.armed && st_r.opc == CMD_STATUS_WRITE_COMMAND &&
            st_nxt.cnt == CNT_STATUS_WRITE_COMMAND) begin
          st_nxt.wrGo = 1'b1;
          st_nxt.isSr = 1'b1;
        end
        if (st_r.armed && st_r.opc == CMD_WRITE &&
            st_nxt.cnt > CNT_ADDR && st_nxt.cnt[2:0] == 3'h0) begin
          st_nxt.wrGo = ~areaProt;
          st_nxt.isSr = 1'b0;
        end
        if (st_r.cnt[2:0] == BIT_LAST && st_r.cnt != 6'h3F) begin
          st_nxt.soV = st_nxt.shift[7];
        end
      end
      if (sckFall && st_r.cnt >= CNT_OPC) begin
        st_nxt.soE = 1'b1;                 // Output after opcode
      end
    end

    // Programming timer
    if (st_r.ws == WS_PROG) begin
      st_nxt.tmr = st_r.tmr + 32'h1;
      if (st_r.tmr >= PROG_CYCLES - 1) begin
        st_nxt.ws  = WS_DONE;
      end
    end else if (st_r.ws == WS_DONE) begin
      st_nxt.ws    = WS_IDLE;
      st_nxt.write_enable_latch   = 1'b0;                 // Latch drops after write
      st_nxt.undef = 1'b0;
    end

    // Low supply overrides the write engine, write frame and latch
    if (low) begin
      if (st_r.ws == WS_PROG) begin
        st_nxt.undef = 1'b1;
      end
      st_nxt.ws    = WS_IDLE;
      st_nxt.wrGo  = 1'b0;
      st_nxt.armed = 1'b0;
      st_nxt.write_enable_latch   = 1'b0;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r      <= '0;
      st_r.csS  <= 2'b11;
      st_r.hldS <= 2'b11;
      st_r.ws   <= WS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign soOut            = st_r.soV;
  assign soOe             = st_r.soE & ~st_r.pause & ~csN;
  assign paused           = st_r.pause;
  assign writeEnableLatch = st_r.write_enable_latch;
  assign writeBusy        = st_r.ws != WS_IDLE;
  assign statusWrite      = st_r.isSr;
  assign cellUndefined    = st_r.undef;
  assign dataByte         = st_r.shift;

  // ****************************************
  // Checks
  // ****************************************
  pause_hiz_a: assert property (@(posedge mclk) disable iff (!arst_n)
    paused |-> !soOe) else $error("output driven while paused");
  pause_freeze_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_r.pause && !csN |=> $stable(st_r.cnt))
    else $error("counter moved while paused");
  desel_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
    csN |=> !paused && st_r.cnt == CNT_ZERO)
    else $error("deselect did not abandon");
  low_wel_a: assert property (@(posedge mclk) disable iff (!arst_n)
    low |=> !writeEnableLatch && !writeBusy)
    else $error("low supply left write state");
  low_undef_a: assert property (@(posedge mclk) disable iff (!arst_n)
    low && st_r.ws == WS_PROG |=> cellUndefined)
    else $error("interrupted cell not marked");
  start_desel_a: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(writeBusy) |-> $past(csN))
    else $error("write started while selected");
  pause_low_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !csN && !sck && !hld |=> paused)
    else $error("pause not entered");
  resume_low_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !csN && !sck && hld |=> !paused)
    else $error("pause not left");
  pause_high_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !csN && sck && st_r.sckD && !paused |=> !paused)
    else $error("pause began with clock high");
  resume_high_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !csN && sck && st_r.sckD && paused |=> paused)
    else $error("pause ended with clock high");
  wr_gate_a: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(st_r.armed) |-> $past(st_r.write_enable_latch))
    else $error("write armed without latch");
endmodule : shg_guard
`default_nettype wire

/* testbench/shg_host_model.sv */
// Host master model driving the serial pins of the guard block
`timescale 1ns/1ps
`default_nettype none
module shg_host_model (
  input  wire logic mclk,      // System clock
  output logic      csPinN,    // Select, low active
  output logic      sckPin,    // Link clock, idle low
  output logic      siPin,     // Serial data
  output logic      pausePinN  // Pause, low active
);
  initial begin
    csPinN    = 1'b1;
    sckPin    = 1'b0;
    siPin     = 1'b0;
    pausePinN = 1'b1;
  end
  // Wait n edges, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : cyc
  // Bits msb first, 4 mclk per half link period
  task automatic sendBits(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      siPin  = v[i];
      cyc(4);
      sckPin = 1'b1;
      cyc(4);
      sckPin = 1'b0;
    end
  endtask : sendBits
  // Bits msb first, link clock left high after the last rise
  task automatic sendHigh(input logic [31:0] v, input int n);
    sendBits(v >> 1, n - 1);
    siPin  = v[0];
    cyc(4);
    sckPin = 1'b1;
    cyc(4);
  endtask : sendHigh
  // Whole frame with select held low throughout
  task automatic frame(input logic [31:0] v, input int n);
    csPinN = 1'b0;
    cyc(4);
    sendBits(v, n);
    cyc(4);
    csPinN = 1'b1;
    siPin  = ~siPin;
    cyc(8);
  endtask : frame
endmodule : shg_host_model
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the pause and low-supply guard block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import shg_pkg::*;
  localparam int unsigned PROG = 20;  // Short programming time
  logic        mclk, arst_n, lowSupply, areaProt, soOut, soOe, paused;
  logic        writeEnableLatch, writeBusy, statusWrite, cellUndefined;
  logic [7:0]  dataByte, rb;
  logic [31:0] seed = 32'h2FFB;
  int          miscompares = 0;
  int          total_checks = 0;
  logic        expBusy;  // Expected write launch
  wire         csPinN, sckPin, siPin, pausePinN;  // Host driven pins
  shg_host_model host (.mclk(mclk), .csPinN(csPinN), .sckPin(sckPin),
    .siPin(siPin), .pausePinN(pausePinN));
  shg_guard #(.PROG_CYCLES(PROG)) shg_guard_inst (.mclk(mclk),
    .arst_n(arst_n), .csPinN(csPinN), .sckPin(sckPin),
    .siPin(siPin), .pausePinN(pausePinN),
    .lowSupply(lowSupply), .areaProt(areaProt), .soOut(soOut),
    .soOe(soOe), .paused(paused), .writeEnableLatch(writeEnableLatch),
    .writeBusy(writeBusy), .statusWrite(statusWrite),
    .cellUndefined(cellUndefined), .dataByte(dataByte));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk1(input string nm, input logic e, input logic s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s expected %b seen %b", nm, e, s);
    end
  endtask : chk1
  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk8
  task automatic wren;
    host.frame(32'(CMD_WREN), 8);
  endtask : wren
  task automatic wr(input logic [7:0] d);
    host.frame({CMD_WRITE, 16'h0000, d}, 32);
  endtask : wr
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #2_000_000;
    miscompares++;
    print_verdict();
  end
  initial begin
    arst_n    = 1'b0;
    lowSupply = 1'b0;
    areaProt  = 1'b0;
    repeat (6) @(posedge mclk);
    #2 arst_n = 1'b1;
    host.cyc(3);
    chk1("wel", 1'b0, writeEnableLatch);
    wr(8'h5A);
    chk1("busy", 1'b0, writeBusy);
    wren();
    chk1("wel", 1'b1, writeEnableLatch);
    host.frame(32'(CMD_WRITE_DISABLED_STATE), 8);
    chk1("wel", 1'b0, writeEnableLatch);
    wren();
    areaProt = 1'b1;
    wr(8'hA5);
    chk1("busy", 1'b0, writeBusy);
    for (int k = 0; k < 3; k++) begin
      rb       = seed[7:0];
      areaProt = seed[8];
      expBusy  = (k == 2) || !seed[8];
      seed     = lfsr(seed);
      wren();
      if (k == 2) host.frame({16'h0000, CMD_STATUS_WRITE_COMMAND, rb}, 16);
      else wr(rb);
      chk1("busy", expBusy, writeBusy);
      chk1("stat", k == 2, statusWrite);
      chk8("data", rb, dataByte);
      chk1("so", rb[7], soOut);
      host.cyc(PROG);
      chk1("wel", !expBusy, writeEnableLatch);
    end
    areaProt = 1'b0;
    wren();
    host.sendBits({CMD_WRITE, 16'h0000, rb}, 32);
    host.cyc(8);
    chk1("busy", 1'b0, writeBusy);
    rb   = seed[7:0];
    seed = lfsr(seed);
    host.csPinN = 1'b0;
    host.sendHigh(32'(rb >> 3), 5);
    host.pausePinN = 1'b0;
    host.cyc(8);
    chk1("paused", 1'b0, paused);
    host.sckPin = 1'b0;
    host.cyc(4);
    chk1("paused", 1'b1, paused);
    chk1("oe", 1'b0, soOe);
    host.sendHigh(32'(~rb), 4);
    host.pausePinN = 1'b1;
    host.cyc(8);
    chk1("paused", 1'b1, paused);
    host.sckPin = 1'b0;
    host.cyc(4);
    chk1("paused", 1'b0, paused);
    host.sendBits(32'(rb), 3);
    host.cyc(4);
    chk8("data", rb, dataByte);
    chk1("so", rb[7], soOut);
    chk1("oe", 1'b1, soOe);
    host.pausePinN = 1'b0;
    host.cyc(4);
    chk1("paused", 1'b1, paused);
    chk1("oe", 1'b0, soOe);
    host.pausePinN = 1'b1;
    host.cyc(4);
    chk1("paused", 1'b0, paused);
    chk1("oe", 1'b1, soOe);
    host.pausePinN = 1'b0;
    host.cyc(4);
    chk1("paused", 1'b1, paused);
    host.csPinN = 1'b1;
    host.cyc(4);
    chk1("paused", 1'b0, paused);
    chk1("oe", 1'b0, soOe);
    host.pausePinN = 1'b1;
    wren();
    wr(8'h3C);
    chk1("busy", 1'b1, writeBusy);
    lowSupply = 1'b1;
    host.cyc(4);
    chk1("busy", 1'b0, writeBusy);
    chk1("wel", 1'b0, writeEnableLatch);
    lowSupply = 1'b0;
    host.cyc(4);
    chk1("undef", 1'b1, cellUndefined);
    wr(8'hC3);
    chk1("busy", 1'b0, writeBusy);
    wren();
    wr(8'hC3);
    host.cyc(PROG);
    chk1("undef", 1'b0, cellUndefined);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
